// [rtl/pcr_regs.svh]
`ifndef PCR_REGS_SVH
`define PCR_REGS_SVH

// Period of the reference clock that drives the whole block.
`define PCR_CLK_PERIOD_NS 40
// Half period of the indicator blink pattern.
`define PCR_BLINK_HALF_NS 250000000
// Half period of the serial indicator clock.
`define PCR_SER_HALF_NS 400
`define PCR_BLINK_CYCLES (`PCR_BLINK_HALF_NS / `PCR_CLK_PERIOD_NS)
`define PCR_SER_CYCLES (`PCR_SER_HALF_NS / `PCR_CLK_PERIOD_NS)
// Half period, in input clocks, forced by a high strap on the clock pin.
`define PCR_STRAP_FAST_HALF 8'h01
// Reset value of a clock divider counter.
`define PCR_DIV_RST 8'h00

`endif

// [rtl/pcr_pkg.sv]
package pcr_pkg;

    typedef enum logic [1:0] {
        PCR_REF_XTAL_25 = 2'b00,
        PCR_REF_OSC_25 = 2'b01,
        PCR_REF_OSC_50 = 2'b10,
        PCR_REF_OSC_125 = 2'b11
    } pcr_refmode_type;

    typedef enum logic [1:0] {
        PCR_RUN_RESET = 2'b00,
        PCR_RUN_START = 2'b01,
        PCR_RUN_ACTIVE = 2'b10
    } pcr_phase_type;

endpackage

// [rtl/pcr_top.sv]
`timescale 1ns/1ps
`include "pcr_regs.svh"
module pcr_top #(
    parameter int BLINK_CYCLES = `PCR_BLINK_CYCLES,
    parameter int SER_CYCLES = `PCR_SER_CYCLES
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic global_power_hold_i,
    input wire logic clk_squelch_i,
    input wire logic line_recovered_clock_i,
    input wire logic ref_clock_output_i,
    input wire logic reference_select_bit0_i,
    input wire logic reference_select_bit1_i,
    input wire logic ref_clk_enable_i,
    input wire logic [7:0] ref_clk_half_i,
    input wire logic rcv_clk_enable_i,
    input wire logic [7:0] rcv_clk_half_i,
    input wire logic serial_mode_i,
    input wire logic blink_enable_i,
    input wire logic indicator_a_on_i,
    input wire logic indicator_b_on_i,
    input wire logic link_fail_detect_i,
    output logic power_down_o,
    output logic ref_clock_output_o,
    output logic ref_clock_output_oe_o,
    output logic line_recovered_clock_out_o,
    output logic indicator_out_a_o,
    output logic indicator_out_b_o,
    output logic link_loss_alert_o,
    output pcr_pkg::pcr_refmode_type ref_mode_o,
    output logic ref_strap_o
);
    import pcr_pkg::*;

    localparam int BW = $clog2(BLINK_CYCLES + 1);
    localparam int SW = $clog2(SER_CYCLES + 1);

    typedef struct packed {
        logic [1:0] rst;
        logic hold_m;
        logic hold_s;
        logic hold_prev;
        logic sq_m;
        logic sq_s;
        logic rc_m;
        logic rc_s;
        logic rc_prev;
        logic pin_m;
        logic pin_s;
        logic [1:0] sel_m;
        logic [1:0] sel_s;
        pcr_phase_type phase;
        logic strap;
        pcr_refmode_type refmode;
        logic pwr_dn;
        logic [7:0] cko_cnt;
        logic cko;
        logic cko_oe;
        logic [7:0] rco_cnt;
        logic rco;
        logic [BW-1:0] blink_cnt;
        logic blink_ph;
        logic [SW-1:0] ser_cnt;
        logic ser_clk;
        logic ser_bit;
        logic [1:0] ser_sh;
        logic ind_a;
        logic ind_b;
        logic alert;
    } pcr_state_type;

    pcr_state_type s_reg;
    pcr_state_type s_next;
    logic run;

    // Advances a half-period counter; bit 8 asks the output to toggle.
    function automatic logic [8:0] div_step(input logic [7:0] cnt,
                                            input logic [7:0] half);
        logic [7:0] lim;
        lim = (half == 8'h00) ? 8'h01 : half;
        if (cnt + 8'h01 >= lim) begin
            div_step = {1'b1, `PCR_DIV_RST};
        end else begin
            div_step = {1'b0, cnt + 8'h01};
        end
    endfunction

    assign run = s_reg.rst[1];

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic [8:0] step;
        logic [7:0] half;
        logic rc_rise;
        logic rco_live;
        logic ser_tick;
        step = 9'h000;
        half = 8'h00;
        rc_rise = 1'b0;
        rco_live = 1'b0;
        ser_tick = 1'b0;
        s_next = s_reg;
        s_next.rst = {s_reg.rst[0], 1'b1};
        s_next.hold_m = global_power_hold_i;
        s_next.hold_s = s_reg.hold_m;
        s_next.hold_prev = s_reg.hold_s;
        s_next.sq_m = clk_squelch_i;
        s_next.sq_s = s_reg.sq_m;
        s_next.rc_m = line_recovered_clock_i;
        s_next.rc_s = s_reg.rc_m;
        s_next.rc_prev = s_reg.rc_s;
        s_next.pin_m = ref_clock_output_i;
        s_next.pin_s = s_reg.pin_m;
        s_next.sel_m = {reference_select_bit1_i, reference_select_bit0_i};
        s_next.sel_s = s_reg.sel_m;
        if (!run) begin
            // Phase, power, clock outputs and indicators sit at their defaults; strap, mode and timers hold.
            s_next.phase = PCR_RUN_RESET;
            s_next.pwr_dn = 1'b1;
            s_next.cko = 1'b0;
            s_next.cko_oe = 1'b0;
            s_next.cko_cnt = `PCR_DIV_RST;
            s_next.rco = 1'b0;
            s_next.rco_cnt = `PCR_DIV_RST;
            s_next.ind_a = 1'b1;
            s_next.ind_b = 1'b1;
            s_next.alert = 1'b0;
        end else begin
            case (s_reg.phase)
                PCR_RUN_RESET: begin
                    s_next.strap = s_reg.pin_s;
                    s_next.refmode = pcr_refmode_type'(s_reg.sel_s);
                    s_next.phase = PCR_RUN_START;
                end
                PCR_RUN_START: begin
                    s_next.phase = PCR_RUN_ACTIVE;
                end
                PCR_RUN_ACTIVE: begin
                    s_next.phase = PCR_RUN_ACTIVE;
                end
                default: begin
                    s_next.phase = PCR_RUN_RESET;
                end
            endcase
            s_next.pwr_dn = s_reg.hold_s;
            // The clock pin is released during reset so the strap can be read.
            s_next.cko_oe = 1'b1;
            half = s_reg.strap ? `PCR_STRAP_FAST_HALF : ref_clk_half_i;
            if (ref_clk_enable_i && s_reg.phase == PCR_RUN_ACTIVE) begin
                step = div_step(s_reg.cko_cnt, half);
                s_next.cko_cnt = step[7:0];
                s_next.cko = s_reg.cko ^ step[8];
            end else begin
                s_next.cko_cnt = `PCR_DIV_RST;
                s_next.cko = 1'b0;
            end
            rc_rise = s_reg.rc_s && !s_reg.rc_prev;
            rco_live = rcv_clk_enable_i && !s_reg.sq_s && !s_reg.pwr_dn;
            if (rco_live) begin
                if (rc_rise) begin
                    step = div_step(s_reg.rco_cnt, rcv_clk_half_i);
                    s_next.rco_cnt = step[7:0];
                    s_next.rco = s_reg.rco ^ step[8];
                end
            end else begin
                s_next.rco_cnt = `PCR_DIV_RST;
                s_next.rco = 1'b0;
            end
            // Blink and serial timing both restart when the power hold lets go.
            if (s_reg.hold_prev && !s_reg.hold_s) begin
                s_next.blink_cnt = '0;
                s_next.blink_ph = 1'b1;
                s_next.ser_cnt = '0;
                s_next.ser_clk = 1'b0;
                s_next.ser_bit = 1'b0;
            end else begin
                if (s_reg.blink_cnt == BW'(BLINK_CYCLES - 1)) begin
                    s_next.blink_cnt = '0;
                    s_next.blink_ph = !s_reg.blink_ph;
                end else begin
                    s_next.blink_cnt = s_reg.blink_cnt + BW'(1);
                end
                ser_tick = (s_reg.ser_cnt == SW'(SER_CYCLES - 1));
                if (ser_tick) begin
                    s_next.ser_cnt = '0;
                    s_next.ser_clk = !s_reg.ser_clk;
                    if (s_reg.ser_clk) begin
                        // Data moves on the falling serial clock edge.
                        s_next.ser_bit = !s_reg.ser_bit;
                        if (s_reg.ser_bit) begin
                            s_next.ser_sh = {indicator_a_on_i,
                                             indicator_b_on_i};
                        end else begin
                            s_next.ser_sh = {s_reg.ser_sh[0], 1'b0};
                        end
                    end
                end else begin
                    s_next.ser_cnt = s_reg.ser_cnt + SW'(1);
                end
            end
            if (s_reg.pwr_dn) begin
                s_next.ind_a = 1'b1;
                s_next.ind_b = 1'b1;
                s_next.alert = 1'b0;
            end else begin
                if (serial_mode_i) begin
                    s_next.ind_a = !s_reg.ser_sh[1];
                    s_next.ind_b = s_reg.ser_clk;
                end else begin
                    s_next.ind_a = !(indicator_a_on_i
                        && (!blink_enable_i || s_reg.blink_ph));
                    s_next.ind_b = !(indicator_b_on_i
                        && (!blink_enable_i || s_reg.blink_ph));
                end
                s_next.alert = link_fail_detect_i;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_reg <= '0;
            s_reg.pwr_dn <= 1'b1;
            s_reg.ind_a <= 1'b1;
            s_reg.ind_b <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign power_down_o = s_reg.pwr_dn;
    assign ref_clock_output_o = s_reg.cko;
    assign ref_clock_output_oe_o = s_reg.cko_oe;
    assign line_recovered_clock_out_o = s_reg.rco;
    assign indicator_out_a_o = s_reg.ind_a;
    assign indicator_out_b_o = s_reg.ind_b;
    assign link_loss_alert_o = s_reg.alert;
    assign ref_mode_o = s_reg.refmode;
    assign ref_strap_o = s_reg.strap;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence hold_release_s;
        run && s_reg.hold_prev && !s_reg.hold_s;
    endsequence

    sequence reset_exit_s;
        $rose(run);
    endsequence

    a_reset_power_down: assert property (!run |=> power_down_o)
        else $error("Power down not held during reset.");
    a_refclk_reset_idle: assert property (
        !run |=> !ref_clock_output_oe_o && !ref_clock_output_o)
        else $error("Reference clock pin active during reset.");
    a_refclk_disabled_low: assert property (
        run && !ref_clk_enable_i |=> !ref_clock_output_o)
        else $error("Disabled reference clock output not low.");
    a_refclk_fast_toggle: assert property (
        run && ref_clk_enable_i && s_reg.strap && s_reg.cko_cnt == 8'h00
        && s_reg.phase == PCR_RUN_ACTIVE
        |=> ref_clock_output_o != $past(ref_clock_output_o))
        else $error("Reference clock output failed to toggle.");
    a_strap_capture: assert property (
        reset_exit_s |=> ref_strap_o == $past(s_reg.pin_s))
        else $error("Clock pin strap not captured at release.");
    a_recov_toggle: assert property (
        run && rcv_clk_enable_i && !s_reg.sq_s && !s_reg.pwr_dn
        && rcv_clk_half_i == 8'h01 && s_reg.rc_s && !s_reg.rc_prev
        |=> $changed(line_recovered_clock_out_o))
        else $error("Recovered clock output missed a line edge.");
    a_recov_reset_low: assert property (
        !run || !rcv_clk_enable_i |=> !line_recovered_clock_out_o)
        else $error("Recovered clock output not low.");
    a_recov_squelch: assert property (
        s_reg.sq_s |=> !line_recovered_clock_out_o)
        else $error("Squelched recovered clock reached the output.");
    a_hold_power_down: assert property (
        run && s_reg.hold_s |=> power_down_o)
        else $error("Power hold did not power down.");
    a_hold_power_up: assert property (
        run && !s_reg.hold_s |=> !power_down_o)
        else $error("Power hold release did not power up.");
    a_hold_blink_sync: assert property (
        hold_release_s |=> s_reg.blink_cnt == '0 && s_reg.blink_ph)
        else $error("Blink timing not restarted on hold release.");
    a_indicator_lit_low: assert property (
        run && !s_reg.pwr_dn && !serial_mode_i && indicator_a_on_i
        && !blink_enable_i |=> !indicator_out_a_o)
        else $error("Lit indicator not driven low.");
    a_serial_clock_out: assert property (
        run && !s_reg.pwr_dn && serial_mode_i
        |=> indicator_out_b_o == $past(s_reg.ser_clk))
        else $error("Serial indicator clock not on output b.");
    a_link_alert: assert property (
        run && !s_reg.pwr_dn && link_fail_detect_i |=> link_loss_alert_o)
        else $error("Link failure not flagged.");
    a_refsel_capture: assert property (
        reset_exit_s |=> ref_mode_o == pcr_refmode_type'($past(s_reg.sel_s)))
        else $error("Reference select not captured at release.");

endmodule

// [testbench/pcr_host_model.sv]
`timescale 1ns/1ps
module pcr_host_model (
    input wire logic clk_i,
    output logic arst_n_o,
    output logic hold_o,
    output logic squelch_o,
    output logic line_clk_o
);
    int unsigned div_cnt;

    initial begin
        arst_n_o = 1'b0;
        hold_o = 1'b0;
        squelch_o = 1'b0;
        line_clk_o = 1'b0;
        div_cnt = 0;
    end

    // The line clock stands in for the media clock, six cycles a period.
    always @(negedge clk_i) begin
        div_cnt = (div_cnt == 2) ? 0 : div_cnt + 1;
        if (div_cnt == 0) begin
            line_clk_o = ~line_clk_o;
        end
    end

    // Reset is let go only after the clock has run for the given cycles.
    task automatic chip_reset(input int cycles);
        arst_n_o = 1'b0;
        repeat (cycles) @(negedge clk_i);
        arst_n_o = 1'b1;
    endtask

    // One hold line is shared by every device on the board.
    task automatic set_hold(input logic v);
        @(negedge clk_i);
        hold_o = v;
    endtask

    task automatic set_squelch(input logic v);
        @(negedge clk_i);
        squelch_o = v;
    endtask
endmodule

// [testbench/test_phy_clock_reset_power_pins.sv]
`timescale 1ns/1ps
module test_phy_clock_reset_power_pins;
    import pcr_pkg::*;
    localparam int SER = 2;
    localparam int BLINK = 8;
    typedef struct packed {
        logic [9:0] e;
        logic [9:0] m;
    } pcr_note_type;
    logic clk_i = 1'b0;
    logic arst_n_i, hold, squelch, line_clk, strap_val, sel0, sel1;
    logic ref_en, rcv_en, ser_mode, blink_en, ind_a, ind_b, fail;
    logic [7:0] ref_half, rcv_half;
    logic pd, ref_o, oe, rcv_o, out_a, out_b, alert, strap;
    pcr_refmode_type mode;
    logic [9:0] obs;
    logic [31:0] r;
    pcr_note_type notes[$];
    pcr_note_type nt;
    event note_ev;
    int fails = 0;
    int compares = 0;
    int cycles = 0;
    // The clock pin is pulled to the strap level whenever it is not driven.
    wire logic pin_level = oe ? ref_o : strap_val;
    assign obs = {pd, ref_o, oe, rcv_o, out_a, out_b, alert, mode, strap};

    pcr_host_model host (.clk_i(clk_i), .arst_n_o(arst_n_i), .hold_o(hold),
        .squelch_o(squelch), .line_clk_o(line_clk));
    pcr_top #(.BLINK_CYCLES(BLINK), .SER_CYCLES(SER)) uut (.clk_i(clk_i),
        .arst_n_i(arst_n_i), .global_power_hold_i(hold),
        .clk_squelch_i(squelch), .line_recovered_clock_i(line_clk),
        .ref_clock_output_i(pin_level), .reference_select_bit0_i(sel0),
        .reference_select_bit1_i(sel1), .ref_clk_enable_i(ref_en),
        .ref_clk_half_i(ref_half), .rcv_clk_enable_i(rcv_en),
        .rcv_clk_half_i(rcv_half), .serial_mode_i(ser_mode),
        .blink_enable_i(blink_en), .indicator_a_on_i(ind_a),
        .indicator_b_on_i(ind_b), .link_fail_detect_i(fail),
        .power_down_o(pd), .ref_clock_output_o(ref_o),
        .ref_clock_output_oe_o(oe), .line_recovered_clock_out_o(rcv_o),
        .indicator_out_a_o(out_a), .indicator_out_b_o(out_b),
        .link_loss_alert_o(alert), .ref_mode_o(mode), .ref_strap_o(strap));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [9:0] seen, input logic [9:0] expv);
        compares++;
        if (seen !== expv) begin
            fails++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic note(input logic [9:0] e, input logic [9:0] m);
        notes.push_back({e, m});
        -> note_ev;
    endtask

    task automatic step(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Waits for a fresh rise of one output bit, then checks its runs.
    task automatic wave(input int b, input int half);
        int n;
        logic [9:0] m;
        n = 0;
        m = 10'h001 << b;
        while (obs[b] !== 1'b0 && n < 200) begin
            step(1);
            n++;
        end
        while (obs[b] !== 1'b1 && n < 200) begin
            step(1);
            n++;
        end
        for (int i = 0; i < 4 * half; i++) begin
            note(((i / half) % 2 == 0) ? m : 10'h000, m);
            step(1);
        end
    endtask

    initial begin
        forever #20 clk_i = ~clk_i;
    end

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            conclude();
        end
    end

    // Takes the oldest expectation whenever the driver announces a result.
    initial begin
        forever begin
            @(note_ev);
            while (notes.size() > 0) begin
                nt = notes.pop_front();
                check(obs & nt.m, nt.e & nt.m);
            end
        end
    end

    initial begin
        r = lfsr(32'ha054);
        {sel1, sel0} = r[1:0];
        {strap_val, ref_en, rcv_en, ser_mode, blink_en} = 5'b01100;
        {ind_a, ind_b, fail} = r[4:2];
        ref_half = 8'h02;
        // Half periods of zero to three line edges; zero counts as one.
        rcv_half = {6'h00, r[6:5]};
        step(3);
        note(10'h230, 10'h3ff);
        host.chip_reset(1);
        step(1);
        note(10'h200, 10'h200);
        step(8);
        note({7'h00, r[1:0], 1'b0}, 10'h207);
        wave(8, 2);
        ref_en = 1'b0;
        step(3);
        for (int i = 0; i < 8; i++) begin
            note(10'h000, 10'h100);
            step(1);
        end
        for (int i = 0; i < 60 && rcv_o !== 1'b1; i++) begin
            step(1);
        end
        note(10'h040, 10'h040);
        for (int k = 0; k < 2; k++) begin
            if (k == 0) host.set_squelch(1'b1);
            else rcv_en = 1'b0;
            step(4);
            for (int i = 0; i < 24; i++) begin
                note(10'h000, 10'h040);
                step(1);
            end
            host.set_squelch(1'b0);
        end
        for (int k = 0; k < 6; k++) begin
            r = lfsr(r);
            {ind_a, ind_b, fail} = r[2:0];
            step(1);
            note({4'h0, ~r[2], ~r[1], r[0], 3'h0}, 10'h038);
        end
        {ind_a, ind_b, fail} = 3'b111;
        host.set_hold(1'b1);
        step(4);
        note(10'h220, 10'h228);
        host.set_hold(1'b0);
        step(4);
        note(10'h008, 10'h208);
        blink_en = 1'b1;
        wave(5, BLINK);
        blink_en = 1'b0;
        ser_mode = 1'b1;
        wave(4, SER);
        // Both indicators are lit, so every serial data slot reads low.
        for (int i = 0; i < 4; i++) begin
            note(10'h000, 10'h020);
            step(1);
        end
        ser_mode = 1'b0;
        r = lfsr(r);
        {sel1, sel0} = r[1:0];
        ref_half = r[9:2];
        {strap_val, ref_en} = 2'b11;
        host.chip_reset(4);
        step(8);
        note({7'h00, r[1:0], 1'b1}, 10'h007);
        wave(8, 1);
        step(2);
        conclude();
    end
endmodule
